// [common/pca_pkg.sv]
// Purpose: Constants and types for the counter array core.
// Assumes: 125 MHz system clock; byte-wide special function register access.
// Notes: Bit positions follow the mode and configuration register layouts.
// What this block does
// [R01] One shared 16-bit counter, six modules
// [R02] Low byte read snapshots high byte
// [R03] Counter reads never disturb counting
// [R04] Three-bit timebase select chooses count source
// [R05] External input counts falling edges, quarter rate
// [R06] Oscillator sources synchronised before counting
// [R07] Counter wrap sets overflow flag
// [R08] Overflow flag interrupts only when enabled
// [R09] Software alone clears overflow flag
// [R10] Idle suspend zero keeps counting in idle
// [R11] Intermediate flag on overflow of bit 8-11
// [R12] Flags set regardless of interrupt enables
// [R13] Each flag has its own enable
// [R14] Reset enters watchdog mode, restricts writes
// [R15] Capture edges selected by bits 5 and 4
// [R16] Cycle length field picks 8-11 bit PWM
// [R17] All PWM modules share one cycle length
// [R18] Comparator off: no toggle, PWM low
// [R19] Config bit 7 selects reload registers
// [R20] Match enable sets flag on PWM match
// [R21] Mode bit 0 enables module interrupt
// [R22] Config bit 5 enables intermediate interrupt
// [R23] Software alone clears module flags
// [R24] Interrupt is OR of enabled flags
// [R25] Idle suspend one halts counter in idle
package pca_pkg;
   localparam int NUM_MODULES = 6;
   localparam int WDT_MODULE  = 5;
   // Register select codes on the byte access port
   localparam logic [3:0] ADDR_CNT_LO   = 4'h0;
   localparam logic [3:0] ADDR_CNT_HI   = 4'h1;
   localparam logic [3:0] ADDR_MODE     = 4'h2;
   localparam logic [3:0] ADDR_PWM_CFG  = 4'h3;
   localparam logic [3:0] ADDR_FLAGS    = 4'h4;
   localparam logic [3:0] ADDR_MOD_MODE = 4'h5;
   localparam logic [3:0] ADDR_CMP_LO   = 4'h6;
   localparam logic [3:0] ADDR_CMP_HI   = 4'h7;
   // Counter mode register fields
   localparam int MODE_IDLE_BIT   = 7;
   localparam int MODE_WDT_BIT    = 6;
   localparam int MODE_TB_LSB     = 1;
   localparam int MODE_OVF_IE_BIT = 0;
   localparam logic [7:0] MODE_RESET = 8'h40;
   // Module mode register fields
   localparam int MM_CMP_EN  = 6;
   localparam int MM_CAP_R   = 5;
   localparam int MM_CAP_F   = 4;
   localparam int MM_MATCH   = 3;
   localparam int MM_TOGGLE  = 2;
   localparam int MM_PWM     = 1;
   localparam int MM_IE      = 0;
   localparam int MM_PWM16   = 7;
   // PWM configuration register fields
   localparam int PC_RELOAD_SEL = 7;
   localparam int PC_IOVF_FLAG  = 6;
   localparam int PC_IOVF_IE    = 5;
   localparam int PC_CLEN_LSB   = 0;
   // Flags register: bit 7 counter overflow, bits 5..0 module flags
   localparam int FL_OVF_BIT = 7;
   // Timebase divider figures
   localparam int DIV_SLOW = 12;
   localparam int DIV_FAST = 4;
   localparam int DIV_OSC  = 8;
   typedef enum logic [2:0] {
      PCA_TB_DIV12 = 3'h0, PCA_TB_DIV4 = 3'h1, PCA_TB_T0 = 3'h2, PCA_TB_EXT = 3'h3,
      PCA_TB_SYS = 3'h4, PCA_TB_XOSC = 3'h5, PCA_TB_LFO = 3'h6, PCA_TB_RSVD = 3'h7
   } pca_tb_e;
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [3:0] addr;
      logic [2:0] sel;
      logic [7:0] wdata;
   } pca_bus_s;
endpackage

// [hdl/pca_module.sv]
// Purpose: One capture/compare module of the counter array.
// Assumes: Counter and its tick come from the core; pin input already synchronised.
// Notes: Capture and compare registers are written through the core.
`timescale 1ns/10ps
`default_nettype none
module pca_module (
   input  wire logic        core_clk_in,
   input  wire logic        rst_in,
   input  wire logic        tick_in,
   input  wire logic [15:0] count_in,
   input  wire logic [7:0]  mode_in,
   input  wire logic [1:0]  cycle_len_in,
   input  wire logic        nbit_ovf_in,
   input  wire logic [15:0] cmp_in,
   input  wire logic [15:0] reload_in,
   input  wire logic        pin_in,
   output logic             cap_out,
   output logic [15:0]      cap_value_out,
   output logic             load_out,
   output logic             event_out,
   output logic             line_out
);
   logic        pin_q;
   logic        match;
   logic [10:0] mask;
   logic        pwm8;
   logic        pwm_enable;
   logic        pwm16;
   always_comb begin
      case (cycle_len_in)
         2'h0:    mask = 11'h0ff;
         2'h1:    mask = 11'h1ff;
         2'h2:    mask = 11'h3ff;
         default: mask = 11'h7ff;
      endcase
   end
   assign pwm16 = mode_in[pca_pkg::MM_PWM] & mode_in[pca_pkg::MM_PWM16] & ~mode_in[pca_pkg::MM_TOGGLE];
   assign pwm8  = mode_in[pca_pkg::MM_PWM] & ~mode_in[pca_pkg::MM_TOGGLE] & ~pwm16 &
                  (cycle_len_in == 2'h0); // [R16] [R17]
   assign pwm_enable  = mode_in[pca_pkg::MM_PWM] & ~mode_in[pca_pkg::MM_TOGGLE] & ~pwm16 & (cycle_len_in != 2'h0);
   always_comb begin
      if (pwm16) match = (count_in == cmp_in);
      else if (pwm8) match = (count_in[7:0] == cmp_in[7:0]);
      else if (pwm_enable) match = ((count_in[10:0] & mask) == (cmp_in[10:0] & mask));
      else match = (count_in == cmp_in);
   end
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) pin_q <= 1'b0;
      else pin_q <= pin_in;
   end
   // Capture on selected edges; comparator bits must be clear
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         cap_out       <= 1'b0;
         cap_value_out <= 16'h0000;
      end else begin
         cap_out <= ~mode_in[pca_pkg::MM_CMP_EN] & ~mode_in[pca_pkg::MM_MATCH] & ~mode_in[pca_pkg::MM_PWM] &
                    ((mode_in[pca_pkg::MM_CAP_R] & pin_in & ~pin_q) |
                     (mode_in[pca_pkg::MM_CAP_F] & ~pin_in & pin_q)); // [R15]
         cap_value_out <= count_in;
      end
   end
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) event_out <= 1'b0;
      else event_out <= cap_out | (tick_in & match & mode_in[pca_pkg::MM_CMP_EN] & mode_in[pca_pkg::MM_MATCH]); // [R20]
   end
   assign load_out = pwm_enable & nbit_ovf_in;
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) line_out <= 1'b0;
      else if ((pwm8 | pwm_enable | pwm16) & ~mode_in[pca_pkg::MM_CMP_EN]) line_out <= 1'b0; // [R18]
      else if (tick_in & mode_in[pca_pkg::MM_CMP_EN]) begin
         if (mode_in[pca_pkg::MM_TOGGLE] & match) line_out <= ~line_out;
         else if ((pwm8 | pwm_enable | pwm16) & match) line_out <= 1'b1;
         else if (pwm8 & count_in[7:0] == 8'hff) line_out <= 1'b0;
         else if (pwm_enable & nbit_ovf_in) line_out <= 1'b0;
         else if (pwm16 & count_in == 16'hffff) line_out <= 1'b0;
      end
   end
   toggle_off_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (!mode_in[pca_pkg::MM_CMP_EN] && !mode_in[pca_pkg::MM_PWM] && $past(!mode_in[pca_pkg::MM_CMP_EN])) |=>
      $stable(line_out)) else $error("line toggled with comparator off"); // [R18]
   pwm_low_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (mode_in[pca_pkg::MM_PWM] && !mode_in[pca_pkg::MM_TOGGLE] && !mode_in[pca_pkg::MM_CMP_EN]) |=> !line_out)
      else $error("PWM output not low when comparator off"); // [R18]
   cap_edge_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      cap_out |-> $past(mode_in[pca_pkg::MM_CAP_R] | mode_in[pca_pkg::MM_CAP_F]))
      else $error("capture without enabled edge"); // [R15]
endmodule
`default_nettype wire

// [hdl/pca_core.sv]
// Purpose: Counter array core: timebase, counter, flags, interrupt and module registers.
// Assumes: Byte register port from the processor; pins and oscillators are asynchronous.
// Notes: Watchdog behaviour of module 5 is limited to locking configuration writes.
`timescale 1ns/10ps
`default_nettype none
module pca_core #(
   parameter int NUM = pca_pkg::NUM_MODULES
) (
   input  wire logic             core_clk_in,
   input  wire logic             rst_in,
   input  wire pca_pkg::pca_bus_s bus_in,
   input  wire logic             cpu_idle_in,
   input  wire logic             t0_ovf_in,
   input  wire logic             external_count_input_in,
   input  wire logic             xosc_in,
   input  wire logic             lfo_in,
   input  wire logic [NUM-1:0]   module_io_line_in,
   output logic [7:0]            rdata_out,
   output logic [NUM-1:0]        module_io_line_out,
   output logic                  irq_out
);
   if (NUM != pca_pkg::NUM_MODULES) begin : g_bad_num
      $error("module count must be six");
   end
   logic [15:0]           count;
   logic [7:0]            snapshot;
   logic [7:0]            mode_reg;
   logic [7:0]            pwm_cfg;
   logic                  ovf_flag;
   logic [NUM-1:0]        mod_flag;
   logic [7:0]            mm [NUM];
   logic [15:0]           cmp [NUM];
   logic [15:0]           rld [NUM];
   logic [2:0]            ext_s;
   logic [2:0]            xosc_s;
   logic [2:0]            lfo_s;
   logic [NUM-1:0]        pin_m;
   logic [NUM-1:0]        pin_s;
   logic [3:0]            div_cnt;
   logic [2:0]            osc_div_x;
   logic [2:0]            osc_div_l;
   logic                  tick;
   logic                  nbit_ovf;
   logic                  run;
   logic                  wdt_lock;
   logic [NUM-1:0]        cap;
   logic [NUM-1:0]        load;
   logic [NUM-1:0]        evt;
   logic [NUM-1:0]        line;
   logic [15:0]           capv [NUM];
   logic [1:0]            cycle_len;
   logic                  wr_mod;
   assign cycle_len = pwm_cfg[pca_pkg::PC_CLEN_LSB +: 2];
   assign wdt_lock = mode_reg[pca_pkg::MODE_WDT_BIT]; // [R14]
   assign run      = ~(mode_reg[pca_pkg::MODE_IDLE_BIT] & cpu_idle_in); // [R10] [R25]
   // Two-stage synchronisers; third stage feeds edge detection
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ext_s  <= 3'h7;
         xosc_s <= 3'h0;
         lfo_s  <= 3'h0;
         pin_m  <= '0;
         pin_s  <= '0;
      end else begin
         ext_s  <= {ext_s[1:0], external_count_input_in};
         xosc_s <= {xosc_s[1:0], xosc_in}; // [R06]
         lfo_s  <= {lfo_s[1:0], lfo_in}; // [R06]
         pin_m  <= module_io_line_in;
         pin_s  <= pin_m;
      end
   end
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) div_cnt <= 4'h0;
      else if (div_cnt == 4'(pca_pkg::DIV_SLOW - 1)) div_cnt <= 4'h0;
      else div_cnt <= div_cnt + 4'h1;
   end
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         osc_div_x <= 3'h0;
         osc_div_l <= 3'h0;
      end else begin
         if (xosc_s[1] & ~xosc_s[2]) osc_div_x <= osc_div_x + 3'h1;
         if (lfo_s[1] & ~lfo_s[2]) osc_div_l <= osc_div_l + 3'h1;
      end
   end
   always_comb begin
      case (pca_pkg::pca_tb_e'(mode_reg[pca_pkg::MODE_TB_LSB +: 3])) // [R04]
         pca_pkg::PCA_TB_DIV12: tick = (div_cnt == 4'h0);
         pca_pkg::PCA_TB_DIV4:  tick = (div_cnt[1:0] == 2'h0) & (div_cnt < 4'(pca_pkg::DIV_SLOW));
         pca_pkg::PCA_TB_T0:    tick = t0_ovf_in;
         pca_pkg::PCA_TB_EXT:   tick = ~ext_s[1] & ext_s[2]; // [R05]
         pca_pkg::PCA_TB_SYS:   tick = 1'b1;
         pca_pkg::PCA_TB_XOSC:  tick = xosc_s[1] & ~xosc_s[2] & (osc_div_x == 3'(pca_pkg::DIV_OSC - 1));
         pca_pkg::PCA_TB_LFO:   tick = lfo_s[1] & ~lfo_s[2] & (osc_div_l == 3'(pca_pkg::DIV_OSC - 1));
         default:               tick = 1'b0;
      endcase
   end
   // Count ticks are dropped while suspended in idle
   logic tick_run;
   assign tick_run = tick & run;
   always_comb begin
      case (cycle_len) // [R11]
         2'h0:    nbit_ovf = tick_run & (count[7:0] == 8'hff);
         2'h1:    nbit_ovf = tick_run & (count[8:0] == 9'h1ff);
         2'h2:    nbit_ovf = tick_run & (count[9:0] == 10'h3ff);
         default: nbit_ovf = tick_run & (count[10:0] == 11'h7ff);
      endcase
   end
   // Counter: bus reads never touch it
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) count <= 16'h0000;
      else if (bus_in.wr & ~wdt_lock & bus_in.addr == pca_pkg::ADDR_CNT_LO) count[7:0] <= bus_in.wdata;
      else if (bus_in.wr & ~wdt_lock & bus_in.addr == pca_pkg::ADDR_CNT_HI) count[15:8] <= bus_in.wdata;
      else if (tick_run) count <= count + 16'h0001; // [R01] [R03]
   end
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) snapshot <= 8'h00;
      else if (bus_in.rd & bus_in.addr == pca_pkg::ADDR_CNT_LO) snapshot <= count[15:8]; // [R02]
   end
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) mode_reg <= pca_pkg::MODE_RESET; // [R14]
      else if (bus_in.wr & bus_in.addr == pca_pkg::ADDR_MODE) begin
         if (wdt_lock) mode_reg[pca_pkg::MODE_WDT_BIT] <= bus_in.wdata[pca_pkg::MODE_WDT_BIT];
         else mode_reg <= bus_in.wdata;
      end
   end
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) pwm_cfg <= 8'h00;
      else begin
         if (bus_in.wr & bus_in.addr == pca_pkg::ADDR_PWM_CFG) begin
            pwm_cfg <= bus_in.wdata;
            pwm_cfg[pca_pkg::PC_IOVF_FLAG] <= bus_in.wdata[pca_pkg::PC_IOVF_FLAG] | nbit_ovf;
         end else if (nbit_ovf) pwm_cfg[pca_pkg::PC_IOVF_FLAG] <= 1'b1; // [R11] [R12]
      end
   end
   // Set wins over a software write in the same cycle
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) ovf_flag <= 1'b0;
      else if (tick_run & count == 16'hffff) ovf_flag <= 1'b1; // [R07] [R12]
      else if (bus_in.wr & bus_in.addr == pca_pkg::ADDR_FLAGS) ovf_flag <= bus_in.wdata[pca_pkg::FL_OVF_BIT]; // [R09]
   end
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) mod_flag <= '0;
      else if (bus_in.wr & bus_in.addr == pca_pkg::ADDR_FLAGS) mod_flag <= bus_in.wdata[NUM-1:0] | evt; // [R23]
      else mod_flag <= mod_flag | evt; // [R12]
   end
   assign wr_mod = bus_in.wr & (bus_in.sel < 3'(NUM));
   generate
      for (genvar i = 0; i < NUM; i++) begin : g_mod
         logic lock_i;
         assign lock_i = wdt_lock & (i == pca_pkg::WDT_MODULE);
         always_ff @(posedge core_clk_in or posedge rst_in) begin
            if (rst_in) mm[i] <= 8'h00;
            else if (wr_mod & ~lock_i & bus_in.sel == 3'(i) & bus_in.addr == pca_pkg::ADDR_MOD_MODE)
               mm[i] <= bus_in.wdata;
            else if (wr_mod & ~lock_i & bus_in.sel == 3'(i) & ~pwm_cfg[pca_pkg::PC_RELOAD_SEL] &
                     bus_in.addr == pca_pkg::ADDR_CMP_LO) mm[i][pca_pkg::MM_CMP_EN] <= 1'b0;
            else if (wr_mod & ~lock_i & bus_in.sel == 3'(i) & ~pwm_cfg[pca_pkg::PC_RELOAD_SEL] &
                     bus_in.addr == pca_pkg::ADDR_CMP_HI) mm[i][pca_pkg::MM_CMP_EN] <= 1'b1;
         end
         always_ff @(posedge core_clk_in or posedge rst_in) begin
            if (rst_in) begin
               cmp[i] <= 16'h0000;
               rld[i] <= 16'h0000;
            end else begin
               if (cap[i]) cmp[i] <= capv[i];
               else if (load[i]) cmp[i] <= rld[i];
               else if (mm[i][pca_pkg::MM_PWM] & ~mm[i][pca_pkg::MM_TOGGLE] & cycle_len == 2'h0 &
                        tick_run & count[7:0] == 8'hff) cmp[i][7:0] <= cmp[i][15:8];
               else if (wr_mod & bus_in.sel == 3'(i) & ~pwm_cfg[pca_pkg::PC_RELOAD_SEL]) begin // [R19]
                  if (bus_in.addr == pca_pkg::ADDR_CMP_LO) cmp[i][7:0] <= bus_in.wdata;
                  if (bus_in.addr == pca_pkg::ADDR_CMP_HI) cmp[i][15:8] <= bus_in.wdata;
               end
               if (wr_mod & bus_in.sel == 3'(i) & pwm_cfg[pca_pkg::PC_RELOAD_SEL]) begin // [R19]
                  if (bus_in.addr == pca_pkg::ADDR_CMP_LO) rld[i][7:0] <= bus_in.wdata;
                  if (bus_in.addr == pca_pkg::ADDR_CMP_HI) rld[i][15:8] <= bus_in.wdata;
               end
            end
         end
         pca_module u_mod (
            .core_clk_in   (core_clk_in),
            .rst_in        (rst_in),
            .tick_in       (tick_run),
            .count_in      (count),
            .mode_in       (mm[i]),
            .cycle_len_in  (cycle_len),
            .nbit_ovf_in   (nbit_ovf),
            .cmp_in        (cmp[i]),
            .reload_in     (rld[i]),
            .pin_in        (pin_s[i]),
            .cap_out       (cap[i]),
            .cap_value_out (capv[i]),
            .load_out      (load[i]),
            .event_out     (evt[i]),
            .line_out      (line[i])
         );
      end
   endgenerate
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) module_io_line_out <= '0;
      else module_io_line_out <= line;
   end
   // Interrupt: each flag gated by its own enable
   logic [NUM-1:0] mod_ie;
   always_comb begin
      for (int k = 0; k < NUM; k++) mod_ie[k] = mm[k][pca_pkg::MM_IE]; // [R21]
   end
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) irq_out <= 1'b0;
      else irq_out <= (ovf_flag & mode_reg[pca_pkg::MODE_OVF_IE_BIT]) | // [R08] [R13] [R24]
                      (pwm_cfg[pca_pkg::PC_IOVF_FLAG] & pwm_cfg[pca_pkg::PC_IOVF_IE]) | // [R22]
                      |(mod_flag & mod_ie);
   end
   // Read port; high byte returns the snapshot
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) rdata_out <= 8'h00;
      else if (bus_in.rd) begin
         case (bus_in.addr)
            pca_pkg::ADDR_CNT_LO:   rdata_out <= count[7:0];
            pca_pkg::ADDR_CNT_HI:   rdata_out <= snapshot; // [R02]
            pca_pkg::ADDR_MODE:     rdata_out <= mode_reg;
            pca_pkg::ADDR_PWM_CFG:  rdata_out <= pwm_cfg;
            pca_pkg::ADDR_FLAGS:    rdata_out <= {ovf_flag, 1'b0, mod_flag};
            pca_pkg::ADDR_MOD_MODE: rdata_out <= (bus_in.sel < 3'(NUM)) ? mm[bus_in.sel] : 8'h00;
            pca_pkg::ADDR_CMP_LO:   rdata_out <= (bus_in.sel >= 3'(NUM)) ? 8'h00 :
                                                 pwm_cfg[pca_pkg::PC_RELOAD_SEL] ? rld[bus_in.sel][7:0] : cmp[bus_in.sel][7:0];
            pca_pkg::ADDR_CMP_HI:   rdata_out <= (bus_in.sel >= 3'(NUM)) ? 8'h00 :
                                                 pwm_cfg[pca_pkg::PC_RELOAD_SEL] ? rld[bus_in.sel][15:8] : cmp[bus_in.sel][15:8];
            default:                rdata_out <= 8'h00;
         endcase
      end
   end
   snap_hold_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (bus_in.rd && bus_in.addr == pca_pkg::ADDR_CNT_LO) |=> snapshot == $past(count[15:8]))
      else $error("snapshot not taken on low byte read"); // [R02]
   count_step_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (tick_run && !bus_in.wr) |=> count == $past(count) + 16'h0001)
      else $error("counter did not advance"); // [R03]
   wrap_flag_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (tick_run && count == 16'hffff) |=> ovf_flag && count == 16'h0000)
      else $error("wrap did not set overflow flag"); // [R07]
   flag_sticky_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (ovf_flag && !(bus_in.wr && bus_in.addr == pca_pkg::ADDR_FLAGS)) |=> ovf_flag)
      else $error("overflow flag cleared without write"); // [R09]
   irq_gate_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (ovf_flag && mode_reg[pca_pkg::MODE_OVF_IE_BIT]) |=> irq_out)
      else $error("enabled overflow did not interrupt"); // [R08]
   idle_hold_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (!run && !bus_in.wr) |=> $stable(count))
      else $error("counter moved while suspended"); // [R25]
   iovf_set_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      nbit_ovf |=> pwm_cfg[pca_pkg::PC_IOVF_FLAG])
      else $error("intermediate overflow missed"); // [R11]
   mod_sticky_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (|evt) |=> ((mod_flag & $past(evt)) == $past(evt)))
      else $error("module event lost"); // [R12]
   iovf_irq_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (pwm_cfg[pca_pkg::PC_IOVF_FLAG] && pwm_cfg[pca_pkg::PC_IOVF_IE]) |=> irq_out)
      else $error("enabled intermediate overflow did not interrupt"); // [R22]
   lock_count_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (wdt_lock && bus_in.wr && !tick_run) |=> $stable(count))
      else $error("counter written while locked"); // [R14]
endmodule
`default_nettype wire

// [bench/pca_cpu_model.sv]
// Purpose: Processor side that reaches the core through its byte port.
// Assumes: Requests start 1 ns after a rising edge and last one cycle.
// Notes: Between requests address and data show the inverse of the last ones.
`timescale 1ns/10ps
`default_nettype none
module pca_cpu_model (
   input  wire logic            core_clk_in,
   input  wire logic [7:0]      rdata_in,
   output var pca_pkg::pca_bus_s bus_out
);
   initial bus_out = '0;
   task automatic acc(input logic w, input logic [3:0] a, input logic [2:0] s,
                      input logic [7:0] d, output logic [7:0] q);
      bus_out = '{wr: w, rd: !w, addr: a, sel: s, wdata: d};
      @(posedge core_clk_in);
      #1;
      bus_out = '{wr: 1'b0, rd: 1'b0, addr: ~a, sel: ~s, wdata: ~d};
      q = rdata_in;
      @(posedge core_clk_in);
      #1;
   endtask
endmodule
`default_nettype wire

// [bench/programmable_counter_array_core_tb_top.sv]
// Purpose: Self-checking bench for the counter array core.
// Assumes: Stimulus moves 1 ns after each rising edge.
// Notes: Count rates are measured as low byte differences over 96 cycles.
`timescale 1ns/10ps
`default_nettype none
module programmable_counter_array_core_tb_top;
   logic              clk;
   logic              rst;
   logic              idle;
   logic              t0;
   logic              ext;
   logic              xo;
   logic              lf;
   logic              irq;
   logic [5:0]        pin_i;
   logic [5:0]        line_o;
   logic [7:0]        rdata;
   logic [7:0]        q;
   logic [7:0]        a;
   pca_pkg::pca_bus_s bus;
   int                fail_count = 0;
   int                check_count = 0;
   pca_core dut (.core_clk_in(clk), .rst_in(rst), .bus_in(bus), .cpu_idle_in(idle), .t0_ovf_in(t0),
      .external_count_input_in(ext), .xosc_in(xo), .lfo_in(lf), .module_io_line_in(pin_i),
      .rdata_out(rdata), .module_io_line_out(line_o), .irq_out(irq));
   pca_cpu_model cpu (.core_clk_in(clk), .rdata_in(rdata), .bus_out(bus));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic stop_test();
      if (fail_count == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] ad, input logic [7:0] d);
      cpu.acc(1'b1, ad, 3'h0, d, q);
   endtask
   task automatic rd(input logic [3:0] ad);
      cpu.acc(1'b0, ad, 3'h0, 8'h00, q);
   endtask
   task automatic measure(input logic [7:0] mode, input logic [7:0] exp);
      wr(pca_pkg::ADDR_MODE, mode);
      rd(pca_pkg::ADDR_CNT_LO);
      a = q;
      for (int i = 0; i < 64; i++) begin
         t0 = (i % 4 == 0);
         {ext, xo, lf} = {3{i % 4 < 2}};
         @(posedge clk);
         #1;
      end
      repeat (30) @(posedge clk);
      #1;
      rd(pca_pkg::ADDR_CNT_LO);
      chk(q - a, exp);
   endtask
   task automatic reset_lock();
      rd(pca_pkg::ADDR_MODE);
      chk(q, 8'h40);
      wr(pca_pkg::ADDR_MODE, 8'h48);
      rd(pca_pkg::ADDR_MODE);
      chk(q, 8'h40);
      wr(pca_pkg::ADDR_MODE, 8'h00);
      rd(pca_pkg::ADDR_MODE);
      chk(q, 8'h00);
   endtask
   task automatic rates();
      measure(8'h08, 8'd96);
      measure(8'h02, 8'd24);
      measure(8'h00, 8'd8);
      measure(8'h04, 8'd16);
      measure(8'h06, 8'd16);
      measure(8'h0a, 8'd2);
      measure(8'h0c, 8'd2);
      idle = 1'b1;
      measure(8'h88, 8'd0);
      measure(8'h08, 8'd96);
      idle = 1'b0;
   endtask
   task automatic snap_ovf();
      wr(pca_pkg::ADDR_CNT_LO, 8'hf0);
      wr(pca_pkg::ADDR_CNT_HI, 8'h12);
      rd(pca_pkg::ADDR_CNT_LO);
      repeat (16) @(posedge clk);
      #1;
      rd(pca_pkg::ADDR_CNT_HI);
      chk(q, 8'h12);
      rd(pca_pkg::ADDR_CNT_LO);
      rd(pca_pkg::ADDR_CNT_HI);
      chk(q, 8'h13);
      wr(pca_pkg::ADDR_MODE, 8'h09);
      wr(pca_pkg::ADDR_CNT_LO, 8'h00);
      wr(pca_pkg::ADDR_CNT_HI, 8'hff);
      for (int i = 0; i < 400 && irq !== 1'b1; i++) @(posedge clk);
      #1;
      rd(pca_pkg::ADDR_FLAGS);
      chk(q & 8'h80, 8'h80);
      chk({7'h0, irq}, 8'h01);
      rd(pca_pkg::ADDR_PWM_CFG);
      chk(q & 8'h40, 8'h40);
      wr(pca_pkg::ADDR_MODE, 8'h08);
      rd(pca_pkg::ADDR_FLAGS);
      chk({7'h0, irq}, 8'h00);
      chk(q & 8'h80, 8'h80);
      wr(pca_pkg::ADDR_FLAGS, 8'h00);
      rd(pca_pkg::ADDR_FLAGS);
      chk(q, 8'h00);
   endtask
   task automatic edge_chk(input logic e);
      repeat (8) @(posedge clk);
      #1;
      rd(pca_pkg::ADDR_FLAGS);
      chk(q & 8'h01, {7'h0, e});
      chk({7'h0, irq}, {7'h0, e});
   endtask
   task automatic capture();
      logic [7:0] cm [3];
      cm = '{8'h21, 8'h11, 8'h31};
      for (int i = 0; i < 3; i++) begin
         wr(pca_pkg::ADDR_MOD_MODE, cm[i]);
         wr(pca_pkg::ADDR_FLAGS, 8'h00);
         pin_i[0] = 1'b1;
         edge_chk(1'(3'b101 >> i));
         wr(pca_pkg::ADDR_FLAGS, 8'h00);
         pin_i[0] = 1'b0;
         edge_chk(1'(3'b110 >> i));
      end
   endtask
   task automatic outputs();
      wr(pca_pkg::ADDR_MOD_MODE, 8'h4d);
      wr(pca_pkg::ADDR_CNT_LO, 8'h00);
      wr(pca_pkg::ADDR_CNT_HI, 8'h00);
      wr(pca_pkg::ADDR_CMP_LO, 8'h40);
      wr(pca_pkg::ADDR_CMP_HI, 8'h00);
      wr(pca_pkg::ADDR_FLAGS, 8'h00);
      repeat (80) @(posedge clk);
      #1;
      rd(pca_pkg::ADDR_FLAGS);
      chk(q & 8'h01, 8'h01);
      chk({7'h0, irq}, 8'h01);
      chk({7'h0, line_o[0]}, 8'h01);
      wr(pca_pkg::ADDR_MOD_MODE, 8'h4a);
      wr(pca_pkg::ADDR_FLAGS, 8'h00);
      repeat (300) @(posedge clk);
      #1;
      rd(pca_pkg::ADDR_FLAGS);
      chk(q & 8'h01, 8'h01);
      wr(pca_pkg::ADDR_CMP_LO, 8'h40);
      repeat (300) @(posedge clk);
      #1;
      chk({7'h0, line_o[0]}, 8'h00);
      wr(pca_pkg::ADDR_PWM_CFG, 8'h80);
      wr(pca_pkg::ADDR_CMP_LO, 8'h5a);
      rd(pca_pkg::ADDR_CMP_LO);
      chk(q, 8'h5a);
      wr(pca_pkg::ADDR_PWM_CFG, 8'h40);
      rd(pca_pkg::ADDR_CMP_LO);
      chk(q, 8'h00);
      chk({7'h0, irq}, 8'h00);
      wr(pca_pkg::ADDR_PWM_CFG, 8'h60);
      chk({7'h0, irq}, 8'h01);
   endtask
   initial begin
      {rst, idle, t0, ext, xo, lf, pin_i} = {1'b1, 11'h0};
      repeat (6) @(posedge clk);
      #1;
      rst = 1'b0;
      reset_lock();
      rates();
      snap_ovf();
      capture();
      outputs();
      stop_test();
   end
   initial begin
      #200000;
      fail_count++;
      stop_test();
   end
endmodule
`default_nettype wire
